//--- core/sixteen_bit_capture_compare_timer.sv
// Top of the 16-bit timer with two capture/compare registers.
// Assumes CPU controls on the system clock; trigger pins are asynchronous.
//
// Function
// - Start is not aligned to the count clock; first match may slip one tick.
// - A capture during a read of the second register still happens.
// - Wrap from all ones to zero sets the overflow flag in running modes.
// - Clearing overflow before the next count after wrap has no effect.
// - Reading the running counter never captures into the second register.
// - Trigger inputs are ignored while the timer is stopped.
// - When trigger A is the count clock, it triggers no capture.
// - Both-edge selection on trigger A disables capture from it.
// - Capture on the count clock fall; interrupt on the following rise.
// - Rewriting a compare value near the count may miss or add a match.
// - A register in compare mode does not capture.
// - High pin after reset gives one rise on first start, not on restart.
// - Filter samples at main clock / 8 or count clock; needs two samples.
// - Pulse output toggles when exactly one match hits, not both at once; starts low, stop or disable clears.
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_capture_compare_timer
    import timer16_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [1:0] mode_select_in,
    input wire logic [1:0] clock_select_in,
    input wire logic [1:0] edge_select_a_in,
    input wire logic [1:0] edge_select_b_in,
    input wire logic [1:0] cc_capture_in,
    input wire logic pulse_output_enable_in,
    input wire logic period_wr_in,
    input wire logic second_wr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic overflow_clear_in,
    input wire logic trigger_input_a_in,
    input wire logic trigger_input_b_in,
    output var logic [15:0] up_counter_out,
    output var logic [15:0] period_compare_reg_out,
    output var logic [15:0] second_capture_compare_reg_out,
    output var logic overflow_flag_out,
    output var logic period_match_interrupt_out,
    output var logic second_capture_interrupt_out,
    output var logic timer_out
);
    if (CNT_W != 16) begin : g_width_check
        $error("Only a 16-bit counter is supported.");
    end

    logic rst_q1;
    logic rst_n;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] mask;
    logic tick_rise;
    logic tick_fall;
    logic running;
    logic ext_count;
    logic count_ev;
    logic det_a;
    logic det_b;
    logic pm_hit;
    logic sm_hit;
    logic wrap;
    logic set_cap_a;
    logic set_cap_b;
    logic ovf_hold;
    logic cap_pend_a;
    logic cap_pend_b;
    logic irq_due_a;
    logic irq_due_b;
    logic [15:0] next_counter;
    logic [15:0] next_period;
    logic [15:0] next_second;
    logic next_ovf;
    logic next_ovf_hold;
    logic next_cap_pend_a;
    logic next_cap_pend_b;
    logic next_irq_due_a;
    logic next_irq_due_b;
    logic next_pm_irq;
    logic next_sc_irq;
    logic next_tout;

    trig_if ta ();
    trig_if tb ();

    // Reset release and pin synchronisers.
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
            sync_a <= 2'h0;
            sync_b <= 2'h0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
            sync_a <= {sync_a[0], trigger_input_a_in};
            sync_b <= {sync_b[0], trigger_input_b_in};
        end
    end

    // Prescaler mask; in external count mode the filter runs at / 8.
    always_comb begin
        if (clock_select_in == PSC_DIV4) begin
            mask = MASK_DIV4;
        end else if (clock_select_in == PSC_DIV16) begin
            mask = MASK_DIV16;
        end else if (clock_select_in == PSC_DIV64) begin
            mask = MASK_DIV64;
        end else begin
            mask = MASK_FX8;
        end
    end

    // The prescaler runs free and is never restarted by a timer start.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            div <= DIV_RST;
        end else begin
            div <= div + 6'h01;
        end
    end

    // Count clock edges and filter wiring.
    assign tick_rise = (div & mask) == mask;
    assign tick_fall = (div & mask) == (mask >> 1);
    assign running = mode_select_in != MODE_STOP;
    assign ext_count = clock_select_in == PSC_EXT_A;
    assign ta.pin_sync = sync_a[1];
    assign ta.sample_en = tick_rise;
    assign ta.edge_sel = edge_select_a_in;
    assign ta.run = running;
    assign tb.pin_sync = sync_b[1];
    assign tb.sample_en = tick_rise;
    assign tb.edge_sel = edge_select_b_in;
    assign tb.run = running;
    assign det_a = ta.detect;
    assign det_b = tb.detect;

    trigger_edge_filter u_filt_a (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .t(ta.filter)
    );

    trigger_edge_filter u_filt_b (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .t(tb.filter)
    );

    // Event terms; a write in the match cycle hides that match.
    assign count_ev = running && (ext_count ? det_a : tick_rise);
    assign pm_hit = count_ev && !cc_capture_in[0] && !period_wr_in &&
        up_counter_out == period_compare_reg_out;
    assign sm_hit = count_ev && !cc_capture_in[1] && !second_wr_in &&
        up_counter_out == second_capture_compare_reg_out;
    assign wrap = count_ev && up_counter_out == CNT_MAX;
    // Only trigger edges load captures, never a counter read.
    assign set_cap_b = det_a && cc_capture_in[1] && !ext_count &&
        edge_select_a_in != EDGE_BOTH;
    assign set_cap_a = det_b && cc_capture_in[0];

    // Next values of counter, registers, flags and pulse output.
    always_comb begin
        next_counter = up_counter_out;
        next_period = period_compare_reg_out;
        next_second = second_capture_compare_reg_out;
        next_ovf_hold = ovf_hold;
        next_cap_pend_a = set_cap_a | cap_pend_a;
        next_cap_pend_b = set_cap_b | cap_pend_b;
        next_irq_due_a = irq_due_a;
        next_irq_due_b = irq_due_b;
        next_tout = timer_out;
        if (!running) begin
            next_counter = CNT_RST;
            next_ovf_hold = 1'b0;
        end else if (mode_select_in == MODE_EDGE_CLR && det_a) begin
            next_counter = CNT_RST;
        end else if (count_ev) begin
            if (mode_select_in == MODE_MATCH_CLR && pm_hit) begin
                next_counter = CNT_RST;
            end else begin
                next_counter = up_counter_out + 16'h0001;
            end
        end
        if (wrap) begin
            next_ovf_hold = 1'b1;
        end else if (count_ev) begin
            next_ovf_hold = 1'b0;
        end
        next_ovf = wrap || ovf_hold ||
            (overflow_flag_out && !overflow_clear_in);
        if (period_wr_in) begin
            next_period = wr_data_in;
        end
        if (second_wr_in) begin
            next_second = wr_data_in;
        end
        // Captures land on the count clock fall, even during a read.
        if (tick_fall && cap_pend_a) begin
            next_period = up_counter_out;
            next_cap_pend_a = set_cap_a;
            next_irq_due_a = 1'b1;
        end
        if (tick_fall && cap_pend_b) begin
            next_second = up_counter_out;
            next_cap_pend_b = set_cap_b;
            next_irq_due_b = 1'b1;
        end
        next_pm_irq = pm_hit || (irq_due_a && tick_rise);
        next_sc_irq = sm_hit || (irq_due_b && tick_rise);
        if (tick_rise) begin
            next_irq_due_a = 1'b0;
            next_irq_due_b = 1'b0;
        end
        if (!running || !pulse_output_enable_in) begin
            next_tout = 1'b0;
        end else if (pm_hit ^ sm_hit) begin
            next_tout = !timer_out;
        end
    end

    // Timer state registers.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            up_counter_out <= CNT_RST;
            period_compare_reg_out <= CC_RST;
            second_capture_compare_reg_out <= CC_RST;
            overflow_flag_out <= 1'b0;
            ovf_hold <= 1'b0;
            cap_pend_a <= 1'b0;
            cap_pend_b <= 1'b0;
            irq_due_a <= 1'b0;
            irq_due_b <= 1'b0;
            period_match_interrupt_out <= 1'b0;
            second_capture_interrupt_out <= 1'b0;
            timer_out <= 1'b0;
        end else begin
            up_counter_out <= next_counter;
            period_compare_reg_out <= next_period;
            second_capture_compare_reg_out <= next_second;
            overflow_flag_out <= next_ovf;
            ovf_hold <= next_ovf_hold;
            cap_pend_a <= next_cap_pend_a;
            cap_pend_b <= next_cap_pend_b;
            irq_due_a <= next_irq_due_a;
            irq_due_b <= next_irq_due_b;
            period_match_interrupt_out <= next_pm_irq;
            second_capture_interrupt_out <= next_sc_irq;
            timer_out <= next_tout;
        end
    end

    // Checks on the timer behaviour.
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    property p_stop_zero;
        !running |=> up_counter_out == CNT_RST;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("Counter not zero while stopped.");

    property p_wrap_sets_ovf;
        wrap |=> overflow_flag_out && up_counter_out == CNT_RST;
    endproperty
    a_wrap_sets_ovf: assert property (p_wrap_sets_ovf)
        else $error("Wrap did not set overflow.");

    property p_clear_blocked;
        ovf_hold && overflow_clear_in |=> overflow_flag_out;
    endproperty
    a_clear_blocked: assert property (p_clear_blocked)
        else $error("Overflow clear took effect too early.");

    property p_stopped_quiet;
        !running |-> !det_a && !det_b;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet)
        else $error("Trigger edge seen while stopped.");

    property p_no_cap_ext;
        ext_count |-> !set_cap_b;
    endproperty
    a_no_cap_ext: assert property (p_no_cap_ext)
        else $error("Capture from count clock input.");

    property p_no_cap_both;
        edge_select_a_in == EDGE_BOTH |-> !set_cap_b;
    endproperty
    a_no_cap_both: assert property (p_no_cap_both)
        else $error("Capture with both edges selected.");

    property p_cap_on_fall;
        cap_pend_b && tick_fall && !second_wr_in |=>
            second_capture_compare_reg_out == $past(up_counter_out)
            ##[1:64] second_capture_interrupt_out;
    endproperty
    a_cap_on_fall: assert property (p_cap_on_fall)
        else $error("Capture value or interrupt out of order.");

    property p_ppg_toggle;
        pulse_output_enable_in && running && (pm_hit ^ sm_hit) |=>
            timer_out != $past(timer_out);
    endproperty
    a_ppg_toggle: assert property (p_ppg_toggle)
        else $error("Pulse output did not toggle on match.");

    c_wrap: cover property (wrap ##1 overflow_flag_out);
    c_capture: cover property (set_cap_b ##[1:128] irq_due_b);
    c_ppg: cover property (timer_out ##[1:300] !timer_out);
endmodule
`default_nettype wire

//--- core/timer16_pkg.sv
// Shared constants for the 16-bit capture/compare timer.
// Assumes one 40 MHz system clock drives every user of this package.
package timer16_pkg;
    // Mode select codes of the timer mode control bits.
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_EDGE_CLR = 2'h2;
    localparam logic [1:0] MODE_MATCH_CLR = 2'h3;
    // Edge select codes for a trigger input.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Count clock select codes of the prescaler mode bits.
    localparam logic [1:0] PSC_DIV4 = 2'h0;
    localparam logic [1:0] PSC_DIV16 = 2'h1;
    localparam logic [1:0] PSC_DIV64 = 2'h2;
    localparam logic [1:0] PSC_EXT_A = 2'h3;
    // Prescaler width and terminal masks; main clock / 8 samples the pin in external count mode.
    localparam int DIV_W = 6;
    localparam logic [5:0] DIV_RST = 6'h00;
    localparam logic [5:0] MASK_DIV4 = 6'h03;
    localparam logic [5:0] MASK_DIV16 = 6'h0f;
    localparam logic [5:0] MASK_DIV64 = 6'h3f;
    localparam logic [5:0] MASK_FX8 = 6'h07;
    // Counter limits and reset values.
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CC_RST = 16'h0000;
endpackage

//--- core/trig_if.sv
// Interface between the timer core and one trigger input filter.
// Assumes the pin level is already synchronised to the system clock.
`timescale 1ns/10ps
`default_nettype none
interface trig_if;
    logic pin_sync;
    logic sample_en;
    logic [1:0] edge_sel;
    logic run;
    logic detect;
    modport filter (input pin_sync, input sample_en, input edge_sel,
        input run, output detect);
    modport timer (output pin_sync, output sample_en, output edge_sel,
        output run, input detect);
endinterface
`default_nettype wire

//--- core/trigger_edge_filter.sv
// Noise filter and valid-edge detector for one trigger input.
// Assumes a synchronised pin and a one-cycle sample enable from the timer.
`timescale 1ns/10ps
`default_nettype none
module trigger_edge_filter
    import timer16_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    trig_if.filter t
);
    logic last_sample;
    logic level;
    logic armed;
    logic next_last_sample;
    logic next_level;
    logic next_armed;
    logic rise;
    logic fall;

    // A level is accepted only once two successive samples agree.
    always_comb begin
        next_last_sample = last_sample;
        next_level = level;
        next_armed = armed | t.run;
        rise = 1'b0;
        fall = 1'b0;
        if (t.sample_en) begin
            next_last_sample = t.pin_sync;
            if (t.pin_sync == last_sample && (t.run || armed)) begin
                next_level = t.pin_sync;
                rise = t.pin_sync & ~level;
                fall = ~t.pin_sync & level;
            end
        end
    end

    // Level resets low, so a high pin right after reset reads as a rise on
    // the first run; once armed the level tracks while stopped.
    always_comb begin
        t.detect = t.run && ((rise && (t.edge_sel == EDGE_RISE ||
            t.edge_sel == EDGE_BOTH)) || (fall && (t.edge_sel == EDGE_FALL
            || t.edge_sel == EDGE_BOTH)));
    end

    // Filter state registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_sample <= 1'b0;
            level <= 1'b0;
            armed <= 1'b0;
        end else begin
            last_sample <= next_last_sample;
            level <= next_level;
            armed <= next_armed;
        end
    end
endmodule
`default_nettype wire

//--- sim/pulse_source.sv
// External pulse source that drives the two trigger input pins.
// Assumes the bench gives pulse widths in system clock cycles.
`timescale 1ns/10ps
`default_nettype none
module pulse_source #(
    parameter logic INIT_A = 1'b0
)
(
    input wire logic clk_in,
    output var logic pin_a_out,
    output var logic pin_b_out
);
    // Pin levels at time zero; a high A pin exercises the first start.
    initial begin
        pin_a_out = INIT_A;
        pin_b_out = 1'b0;
    end
    // Raises one pin for a number of clocks; pins change at clock falls.
    // Callers keep widths above two count periods except for a glitch.
    task automatic pulse(input logic use_b, input int width);
        @(negedge clk_in);
        if (use_b) pin_b_out = 1'b1;
        else pin_a_out = 1'b1;
        repeat (width) @(negedge clk_in);
        if (use_b) pin_b_out = 1'b0;
        else pin_a_out = 1'b0;
    endtask
    // Moves trigger A to a steady level.
    task automatic set_a(input logic level);
        @(negedge clk_in);
        pin_a_out = level;
    endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the 16-bit capture/compare timer.
// Assumes the design files and the pulse source are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import timer16_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode = MODE_STOP;
    logic [1:0] csel = PSC_DIV4;
    logic [1:0] edge_a = EDGE_RISE;
    logic [1:0] edge_b = EDGE_NONE;
    logic [1:0] cc = 2'h2;
    logic pulse_en = 1'b0;
    logic period_wr = 1'b0;
    logic second_wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic ovf_clr = 1'b0;
    logic pin_a, pin_b, ovf, pm_irq, sc_irq, tout;
    logic [15:0] cnt, period_q, second_q;
    int bad_count = 0;
    int checks_done = 0;

    // The 40 MHz system clock.
    always #12.5 clk = ~clk;

    sixteen_bit_capture_compare_timer DUT (
        .clk_sys_in(clk), .rst_b_in(rst_b), .mode_select_in(mode),
        .clock_select_in(csel), .edge_select_a_in(edge_a),
        .edge_select_b_in(edge_b), .cc_capture_in(cc),
        .pulse_output_enable_in(pulse_en), .period_wr_in(period_wr),
        .second_wr_in(second_wr), .wr_data_in(wdata),
        .overflow_clear_in(ovf_clr), .trigger_input_a_in(pin_a),
        .trigger_input_b_in(pin_b), .up_counter_out(cnt),
        .period_compare_reg_out(period_q),
        .second_capture_compare_reg_out(second_q),
        .overflow_flag_out(ovf), .period_match_interrupt_out(pm_irq),
        .second_capture_interrupt_out(sc_irq), .timer_out(tout));

    pulse_source #(.INIT_A(1'b1)) src (
        .clk_in(clk), .pin_a_out(pin_a), .pin_b_out(pin_b));

    // Prints the verdict and ends the run.
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Compares a 16-bit design value.
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compares a count or cycle figure measured by the bench.
    task automatic check_num(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Stops the timer, changes the selects, then starts it again.
    task automatic restart(input logic [1:0] m, input logic [1:0] c,
        input logic [1:0] ea, input logic [1:0] eb, input logic [1:0] cap);
        @(negedge clk) mode = MODE_STOP;
        @(negedge clk) begin
            csel = c;
            edge_a = ea;
            edge_b = eb;
            cc = cap;
        end
        @(negedge clk) mode = m;
    endtask
    // One-cycle write strobe to the period or the second register.
    task automatic write_reg(input logic to_period, input logic [15:0] d);
        @(negedge clk);
        wdata = d;
        period_wr = to_period;
        second_wr = ~to_period;
        @(negedge clk);
        period_wr = 1'b0;
        second_wr = 1'b0;
    endtask
    // Counts capture interrupts from trigger A over 48 cycles.
    task automatic irq_count(output int n);
        n = 0;
        repeat (48) begin
            @(negedge clk);
            if (sc_irq === 1'b1) n++;
        end
    endtask
    // Pulses one pin and watches the register that pin captures into.
    task automatic watch(input logic use_b, input int width, output int irqs,
        output int gap, output logic val_ok, output logic moved);
        logic [15:0] prev;
        int chg;
        prev = use_b ? period_q : second_q;
        irqs = 0;
        gap = -1;
        chg = -1;
        val_ok = 1'b0;
        fork
            src.pulse(use_b, width);
            for (int i = 0; i < 48; i++) begin
                @(negedge clk);
                if (chg < 0 && (use_b ? period_q : second_q) !== prev) chg = i;
                if ((use_b ? pm_irq : sc_irq) === 1'b1) begin
                    irqs++;
                    gap = i - chg;
                    val_ok = (use_b ? period_q : second_q) === cnt - 16'h0001;
                end
            end
        join
        moved = chg >= 0;
    endtask

    // A high pin gives one edge at the first start, none at a restart.
    task automatic s_first_start;
        int n;
        restart(MODE_FREE, PSC_DIV4, EDGE_RISE, EDGE_NONE, 2'h2);
        irq_count(n);
        check_num(n, 1);
        restart(MODE_FREE, PSC_DIV4, EDGE_RISE, EDGE_NONE, 2'h2);
        irq_count(n);
        check_num(n, 0);
        mode = MODE_STOP;
        src.set_a(1'b0);
    endtask
    // Pulses on both pins while stopped leave everything untouched.
    task automatic s_stopped;
        int n, g;
        logic ok, mv;
        write_reg(1'b1, 16'hfff0);
        write_reg(1'b0, 16'hfff0);
        check_word(period_q, 16'hfff0);
        check_word(second_q, 16'hfff0);
        restart(MODE_STOP, PSC_DIV4, EDGE_RISE, EDGE_FALL, 2'h3);
        for (int k = 0; k < 2; k++) begin
            watch(k[0], 20, n, g, ok, mv);
            check_num(n, 0);
            check_word({15'h0000, mv}, 16'h0000);
            check_word(cnt, 16'h0000);
        end
    endtask
    // Captures from A into the second register and from B into the period.
    task automatic s_capture;
        int n, g;
        logic ok, mv;
        for (int k = 0; k < 2; k++) begin
            if (k == 0) restart(MODE_FREE, PSC_DIV4, EDGE_RISE, EDGE_NONE, 2'h2);
            else restart(MODE_FREE, PSC_DIV4, EDGE_NONE, EDGE_FALL, 2'h1);
            watch(k[0], 20, n, g, ok, mv);
            check_num(n, 1);
            check_num(g, 2);
            check_word({15'h0000, ok}, 16'h0001);
        end
    endtask
    // Compare mode, both edges, A as count clock and a glitch: no capture.
    task automatic s_no_capture;
        logic [1:0] cap [4] = '{2'h0, 2'h2, 2'h2, 2'h2};
        logic [1:0] ea [4] = '{EDGE_RISE, EDGE_BOTH, EDGE_RISE, EDGE_RISE};
        logic [1:0] cs [4] = '{PSC_DIV4, PSC_DIV4, PSC_EXT_A, PSC_DIV4};
        int wid [4] = '{20, 20, 20, 2};
        int n, g;
        logic ok, mv;
        mode = MODE_STOP;
        write_reg(1'b0, 16'hfff0);
        for (int k = 0; k < 4; k++) begin
            restart(MODE_FREE, cs[k], ea[k], EDGE_NONE, cap[k]);
            watch(1'b0, wid[k], n, g, ok, mv);
            check_num(n, 0);
            check_word({15'h0000, mv}, 16'h0000);
            if (cs[k] === PSC_EXT_A) check_word(cnt, 16'h0001);
        end
    endtask
    // Pulse output: period 8, toggle at 3, so 36-cycle period, 20 high.
    task automatic s_pulse_mode;
        int first_pm, gap, up_t, high;
        logic over;
        restart(MODE_STOP, PSC_DIV4, EDGE_NONE, EDGE_NONE, 2'h0);
        write_reg(1'b1, 16'h0008);
        write_reg(1'b0, 16'h0003);
        check_word(period_q, 16'h0008);
        check_word(second_q, 16'h0003);
        pulse_en = 1'b1;
        mode = MODE_MATCH_CLR;
        @(negedge clk);
        check_word({15'h0000, tout}, 16'h0000);
        first_pm = -1;
        gap = -1;
        up_t = -1;
        high = -1;
        over = 1'b0;
        for (int t = 0; t < 120; t++) begin
            @(negedge clk);
            if (cnt > 16'h0008) over = 1'b1;
            if (tout === 1'b1 && up_t < 0) up_t = t;
            if (tout === 1'b0 && up_t >= 0 && high < 0) high = t - up_t;
            if (pm_irq === 1'b1) begin
                if (first_pm < 0) first_pm = t;
                else if (gap < 0) gap = t - first_pm;
            end
        end
        check_num(gap, 36);
        check_num(high, 20);
        check_word({15'h0000, over}, 16'h0000);
        check_word({15'h0000, ovf}, 16'h0000);
        ovf_clr = 1'b1;
        @(negedge clk) ovf_clr = 1'b0;
        check_word({15'h0000, ovf}, 16'h0000);
        pulse_en = 1'b0;
        mode = MODE_STOP;
    endtask
    // Trigger A edges clear the counter at /16 and /64; it reaches 1 one count period later.
    task automatic s_edge_clear;
        int p, zero_t, ones;
        for (int k = 0; k < 2; k++) begin
            p = k ? 64 : 16;
            restart(MODE_EDGE_CLR, k ? PSC_DIV64 : PSC_DIV16, EDGE_RISE,
                EDGE_NONE, 2'h0);
            repeat (3 * p) @(negedge clk);
            zero_t = -1;
            ones = -1;
            fork
                src.pulse(1'b0, 2 * p + 8);
                for (int t = 0; t < 4 * p; t++) begin
                    @(negedge clk);
                    if (zero_t < 0 && cnt === 16'h0000) zero_t = t;
                    if (zero_t >= 0 && ones < 0 && cnt === 16'h0001)
                        ones = t - zero_t;
                end
            join
            check_num(ones, p);
        end
        mode = MODE_STOP;
    endtask

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        check_word(cnt, 16'h0000);
        check_word({15'h0000, tout}, 16'h0000);
        s_first_start;
        s_stopped;
        s_capture;
        s_no_capture;
        s_pulse_mode;
        s_edge_clear;
        close_out;
    end
    // Watchdog well beyond the roughly 1200 cycles the scenarios need.
    initial begin
        #100000;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire
